// *** src/clamp_coast_ctl.sv ***
// Purpose: Clamp pulse, coast selection and auto-offset scheduling with an
//          Avalon-MM register slave.
// Assumes: Hsync, vsync, clamp and coast pins arrive asynchronous to i_clk;
//          hsync and vsync are already active high.
// Notes:   All outputs come from flip-flops.
//
// How it works
// - coast source bit picks vsync or pin
// - coast override picks automatic or programmed polarity
// - programmed coast polarity: 0 low, 1 high
// - clamp source bit picks internal or pin
// - per-channel bit picks ground or midscale clamp
// - clamp starts programmed clocks after hsync end
// - clamp lasts programmed clocks, reset thirty-two
// - clamp override picks automatic or programmed polarity
// - programmed clamp polarity: 0 low, 1 high
// - auto-offset enable triggers offset correction
// - interval field schedules updates, reset every vsync
`timescale 1ns/100ps
module clamp_coast_ctl
    import clamp_ctl_pkg::*;
(
    input  wire logic        i_clk,           // Pixel sample clock, 40 MHz.
    input  wire logic        i_rst,           // Asynchronous reset, active high.
    input  wire logic [7:0]  i_address,       // Avalon byte address.
    input  wire logic        i_read,          // Avalon read request.
    input  wire logic        i_write,         // Avalon write request.
    input  wire logic [31:0] i_writedata,     // Avalon write data.
    input  wire logic [3:0]  i_byteenable,    // Avalon byte enables.
    output logic [31:0]      o_readdata,      // Avalon read data.
    output logic             o_waitrequest,   // Avalon wait request.
    input  wire logic        i_hsync,         // Hsync pin, active high.
    input  wire logic        i_vsync,         // Vsync pin, active high.
    input  wire logic        i_ext_clamp,     // External clamp pin.
    input  wire logic        i_ext_coast,     // External coast pin.
    output logic             o_clamp,         // Clamp active, high.
    output logic             o_coast,         // Coast active, high.
    output logic [2:0]       o_clamp_mid,     // Red, green, blue: 1 midscale.
    output logic             o_offset_update  // Auto-offset update pulse.
);
    typedef enum logic [2:0] {
        CL_IDLE  = 3'b001,
        CL_DELAY = 3'b010,
        CL_PULSE = 3'b100
    } cl_state_t;

    typedef struct packed {
        logic [7:0]  ctrl;
        logic [7:0]  start;
        logic [7:0]  length;
        logic [7:0]  pol_ao;
        logic        ack;
        logic [31:0] rdata;
        logic        hs1;
        logic        hs2;
        logic        hs_prev;
        logic        vs1;
        logic        vs2;
        logic        vs_prev;
        cl_state_t   cl_state;
        logic [7:0]  cl_cnt;
        logic        clamp_prev;
        logic [5:0]  ao_cnt;
        logic        clamp;
        logic        coast;
        logic [2:0]  mid;
        logic        upd;
    } st_t;

    st_t  st_ff;
    st_t  nxt_st;
    logic ext_clamp_act;
    logic ext_coast_act;
    logic hs_fall;
    logic vs_rise;
    logic clamp_rise;
    logic int_clamp;
    logic [1:0] ivl;

    // Byte lane 0 write helper, used by all four registers.
    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] d,
                                           input logic [3:0] be);
        wr_byte = be[0] ? d[7:0] : old;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // External clamp and coast polarity resolution.
    pol_sense #(
        .CNT_W    (12)
    ) u_clamp_pol (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_pin    (i_ext_clamp),
        .i_ovr    (st_ff.pol_ao[BIT_CLAMP_OVR]),
        .i_pol    (st_ff.pol_ao[BIT_CLAMP_POL]),
        .o_active (ext_clamp_act)
    );

    pol_sense #(
        .CNT_W    (12)
    ) u_coast_pol (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_pin    (i_ext_coast),
        .i_ovr    (st_ff.ctrl[BIT_COAST_OVR]),
        .i_pol    (st_ff.ctrl[BIT_COAST_POL]),
        .o_active (ext_coast_act)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection reads only the second synchroniser stage.
    assign hs_fall    = st_ff.hs_prev & ~st_ff.hs2;
    assign vs_rise    = ~st_ff.vs_prev & st_ff.vs2;
    assign int_clamp  = (st_ff.cl_state == CL_PULSE);
    assign clamp_rise = st_ff.clamp & ~st_ff.clamp_prev;
    assign ivl        = st_ff.pol_ao[BIT_AO_IVL_HI:BIT_AO_IVL_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic for bus, clamp timer, coast and offset scheduling.
    always_comb begin
        nxt_st         = st_ff;
        // Bus: one wait cycle per access keeps read data registered.
        nxt_st.ack     = (i_read | i_write) & ~st_ff.ack;
        nxt_st.rdata   = RD_UNMAPPED;
        if (i_write & ~st_ff.ack) begin
            case (i_address)
                ADDR_COAST_CLAMP_CTRL: nxt_st.ctrl   = wr_byte(st_ff.ctrl, i_writedata, i_byteenable);
                ADDR_CLAMP_START:      nxt_st.start  = wr_byte(st_ff.start, i_writedata, i_byteenable);
                ADDR_CLAMP_LENGTH:     nxt_st.length = wr_byte(st_ff.length, i_writedata, i_byteenable);
                ADDR_CLAMP_POL_AO:     nxt_st.pol_ao = wr_byte(st_ff.pol_ao, i_writedata, i_byteenable);
                default: ;
            endcase
        end
        if (i_read & ~st_ff.ack) begin
            case (i_address)
                ADDR_COAST_CLAMP_CTRL: nxt_st.rdata = {24'h0, st_ff.ctrl};
                ADDR_CLAMP_START:      nxt_st.rdata = {24'h0, st_ff.start};
                ADDR_CLAMP_LENGTH:     nxt_st.rdata = {24'h0, st_ff.length};
                ADDR_CLAMP_POL_AO:     nxt_st.rdata = {24'h0, st_ff.pol_ao};
                ADDR_STATUS:           nxt_st.rdata = {27'h0, ext_coast_act, ext_clamp_act,
                                                       st_ff.coast, st_ff.clamp, st_ff.hs2};
                default:               nxt_st.rdata = RD_UNMAPPED;
            endcase
        end
        // Synchronisers and edge history.
        nxt_st.hs1     = i_hsync;
        nxt_st.hs2     = st_ff.hs1;
        nxt_st.hs_prev = st_ff.hs2;
        nxt_st.vs1     = i_vsync;
        nxt_st.vs2     = st_ff.vs1;
        nxt_st.vs_prev = st_ff.vs2;
        // Clamp timer counts pixel clocks; a new hsync end restarts it.
        case (st_ff.cl_state)
            CL_IDLE: begin
                nxt_st.cl_cnt = '0;
            end
            CL_DELAY: begin
                nxt_st.cl_cnt = st_ff.cl_cnt + 8'h01;
                if (st_ff.cl_cnt >= st_ff.start) begin
                    nxt_st.cl_state = CL_PULSE;
                    nxt_st.cl_cnt   = 8'h01;
                end
            end
            CL_PULSE: begin
                nxt_st.cl_cnt = st_ff.cl_cnt + 8'h01;
                if (st_ff.cl_cnt >= st_ff.length) begin
                    nxt_st.cl_state = CL_IDLE;
                end
            end
            default: nxt_st.cl_state = CL_IDLE;
        endcase
        if (hs_fall) begin
            nxt_st.cl_state = CL_DELAY;
            nxt_st.cl_cnt   = 8'h01;
        end
        // A zero length means no pulse at all.
        if (st_ff.length == 8'h00) nxt_st.cl_state = (nxt_st.cl_state == CL_PULSE) ? CL_IDLE : nxt_st.cl_state;
        // Clamp source: internal timer or resolved external pin.
        nxt_st.clamp = st_ff.ctrl[BIT_CLAMP_SRC] ? ext_clamp_act : int_clamp;
        nxt_st.clamp_prev = st_ff.clamp;
        // Coast source: internal follows vsync, since pre/post coast is elsewhere.
        nxt_st.coast = st_ff.ctrl[BIT_COAST_SRC] ? ext_coast_act : st_ff.vs2;
        nxt_st.mid   = {st_ff.ctrl[BIT_RED_MID], st_ff.ctrl[BIT_GREEN_MID], st_ff.ctrl[BIT_BLUE_MID]};
        // Auto-offset scheduling counts clamp starts; the vsync interval follows vsync rises instead.
        nxt_st.upd = 1'b0;
        if (st_ff.pol_ao[BIT_AO_EN]) begin
            case (ivl)
                IVL_EVERY: nxt_st.upd = clamp_rise;
                IVL_16: begin
                    if (clamp_rise) begin
                        nxt_st.upd    = (st_ff.ao_cnt[3:0] == CNT_16_LAST[3:0]);
                        nxt_st.ao_cnt = st_ff.ao_cnt + 6'h01;
                    end
                end
                IVL_64: begin
                    if (clamp_rise) begin
                        nxt_st.upd    = (st_ff.ao_cnt == CNT_64_LAST);
                        nxt_st.ao_cnt = st_ff.ao_cnt + 6'h01;
                    end
                end
                IVL_VSYNC: nxt_st.upd = vs_rise;
                default:   nxt_st.upd = 1'b0;
            endcase
        end else begin
            nxt_st.ao_cnt = '0;
        end
    end

    // State register.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '{ctrl: RST_COAST_CLAMP_CTRL, start: RST_CLAMP_START, length: RST_CLAMP_LENGTH,
                       pol_ao: RST_CLAMP_POL_AO, cl_state: CL_IDLE, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state register.
    assign o_readdata      = st_ff.rdata;
    assign o_waitrequest   = ~st_ff.ack;
    assign o_clamp         = st_ff.clamp;
    assign o_coast         = st_ff.coast;
    assign o_clamp_mid     = st_ff.mid;
    assign o_offset_update = st_ff.upd;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_hs_end;
        hs_fall && !st_ff.ctrl[BIT_CLAMP_SRC] && st_ff.start == 8'h02 && st_ff.length != 8'h00;
    endsequence
    sequence s_quiet_then_pulse;
        (!hs_fall && !int_clamp) [*2] ##1 int_clamp;
    endsequence

    chk_clamp_start_delay: assert property (@(posedge i_clk) disable iff (i_rst)
        s_hs_end |=> s_quiet_then_pulse) else $error("Clamp pulse start delay wrong.");
    chk_clamp_pulse_len: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(int_clamp) && st_ff.length == 8'h03 && $stable(st_ff.length) |->
        (int_clamp || hs_fall) [*3] ##1 (!int_clamp || $past(hs_fall)))
        else $error("Clamp pulse length wrong.");
    chk_clamp_src_ext: assert property (@(posedge i_clk) disable iff (i_rst)
        st_ff.ctrl[BIT_CLAMP_SRC] |=> o_clamp == $past(ext_clamp_act)) else $error("External clamp not used.");
    chk_clamp_src_int: assert property (@(posedge i_clk) disable iff (i_rst)
        !st_ff.ctrl[BIT_CLAMP_SRC] |=> o_clamp == $past(int_clamp)) else $error("Internal clamp not used.");
    chk_coast_src: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_coast == $past(st_ff.ctrl[BIT_COAST_SRC] ? ext_coast_act : st_ff.vs2))
        else $error("Coast source wrong.");
    chk_clamp_pol_ovr: assert property (@(posedge i_clk) disable iff (i_rst)
        st_ff.pol_ao[BIT_CLAMP_OVR] && $stable(st_ff.pol_ao) |=>
        ext_clamp_act == ($past(u_clamp_pol.st_ff.s2) ~^ $past(st_ff.pol_ao[BIT_CLAMP_POL])))
        else $error("Clamp polarity override ignored.");
    chk_coast_pol_ovr: assert property (@(posedge i_clk) disable iff (i_rst)
        st_ff.ctrl[BIT_COAST_OVR] && $stable(st_ff.ctrl) |=>
        ext_coast_act == ($past(u_coast_pol.st_ff.s2) ~^ $past(st_ff.ctrl[BIT_COAST_POL])))
        else $error("Coast polarity override ignored.");
    chk_mid_select: assert property (@(posedge i_clk) disable iff (i_rst)
        ##1 o_clamp_mid == $past({st_ff.ctrl[BIT_RED_MID], st_ff.ctrl[BIT_GREEN_MID], st_ff.ctrl[BIT_BLUE_MID]}))
        else $error("Midscale select wrong.");
    chk_ao_disabled: assert property (@(posedge i_clk) disable iff (i_rst)
        !st_ff.pol_ao[BIT_AO_EN] |=> !o_offset_update) else $error("Update while auto-offset off.");
    chk_ao_vsync: assert property (@(posedge i_clk) disable iff (i_rst)
        st_ff.pol_ao[BIT_AO_EN] && ivl == IVL_VSYNC |=> o_offset_update == $past(vs_rise))
        else $error("Vsync update schedule wrong.");
endmodule

// *** src/clamp_ctl_pkg.sv ***
// Purpose: Shared constants for the clamp, coast and auto-offset control block.
// Assumes: Register offsets are byte addresses on a 32-bit Avalon-MM slave.
// Notes:   Each register sits in the low byte of its word; upper bits read zero.
package clamp_ctl_pkg;
    // Register byte addresses.
    localparam logic [7:0] ADDR_COAST_CLAMP_CTRL = 8'h18;
    localparam logic [7:0] ADDR_CLAMP_START      = 8'h19;
    localparam logic [7:0] ADDR_CLAMP_LENGTH     = 8'h1a;
    localparam logic [7:0] ADDR_CLAMP_POL_AO     = 8'h1b;
    localparam logic [7:0] ADDR_STATUS           = 8'h1c;
    // Reset values.
    localparam logic [7:0] RST_COAST_CLAMP_CTRL  = 8'h20;
    localparam logic [7:0] RST_CLAMP_START       = 8'h08;
    localparam logic [7:0] RST_CLAMP_LENGTH      = 8'h20;
    localparam logic [7:0] RST_CLAMP_POL_AO      = 8'h5b;
    // Field positions of the coast and clamp control register.
    localparam int BIT_COAST_SRC     = 7;
    localparam int BIT_COAST_OVR     = 6;
    localparam int BIT_COAST_POL     = 5;
    localparam int BIT_CLAMP_SRC     = 4;
    localparam int BIT_RED_MID       = 3;
    localparam int BIT_GREEN_MID     = 2;
    localparam int BIT_BLUE_MID      = 1;
    // Field positions of the clamp polarity and auto-offset register.
    localparam int BIT_CLAMP_OVR     = 7;
    localparam int BIT_CLAMP_POL     = 6;
    localparam int BIT_AO_EN         = 5;
    localparam int BIT_AO_IVL_HI     = 4;
    localparam int BIT_AO_IVL_LO     = 3;
    // Auto-offset interval codes.
    localparam logic [1:0] IVL_EVERY = 2'h0;
    localparam logic [1:0] IVL_16    = 2'h1;
    localparam logic [1:0] IVL_64    = 2'h2;
    localparam logic [1:0] IVL_VSYNC = 2'h3;
    localparam logic [5:0] CNT_16_LAST = 6'h0f;
    localparam logic [5:0] CNT_64_LAST = 6'h3f;
    // Read answer for an unmapped address.
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
endpackage

// *** src/pol_sense.sv ***
// Purpose: Synchronises an external level and resolves its active polarity.
// Assumes: The input is asynchronous to i_clk.
// Notes:   In automatic mode the idle level is learned as the last level held
//          long enough to saturate its counter, so the other level counts as active.
`timescale 1ns/100ps
module pol_sense #(
    parameter int CNT_W = 12                  // Width of the idle-level counters.
) (
    input  wire logic i_clk,                  // Pixel clock.
    input  wire logic i_rst,                  // Asynchronous reset, active high.
    input  wire logic i_pin,                  // Raw external pin.
    input  wire logic i_ovr,                  // 1: use i_pol; 0: decide automatically.
    input  wire logic i_pol,                  // 1: active high; 0: active low.
    output logic      o_active                // Registered active-high result.
);
    typedef struct packed {
        logic             s1;
        logic             s2;
        logic [CNT_W-1:0] hi_cnt;
        logic [CNT_W-1:0] lo_cnt;
        logic             auto_pol;
        logic             act;
    } st_t;
    st_t st_ff;
    st_t nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    // The counters saturate so that a long idle stretch decides polarity.
    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = i_pin;
        nxt_st.s2 = st_ff.s1;
        if (st_ff.s2) begin
            if (~&st_ff.hi_cnt) nxt_st.hi_cnt = st_ff.hi_cnt + 1'b1;
            nxt_st.lo_cnt = '0;
        end else begin
            if (~&st_ff.lo_cnt) nxt_st.lo_cnt = st_ff.lo_cnt + 1'b1;
            nxt_st.hi_cnt = '0;
        end
        if (&st_ff.hi_cnt) nxt_st.auto_pol = 1'b0;
        if (&st_ff.lo_cnt) nxt_st.auto_pol = 1'b1;
        nxt_st.act = st_ff.s2 ~^ (i_ovr ? i_pol : st_ff.auto_pol);
    end

    // Reset assumes active high until the idle level is learned.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_ff <= '{auto_pol: 1'b1, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_active = st_ff.act;
endmodule

// *** bench/video_src.sv ***
// Purpose: Video source model driving sync, clamp and coast pins of the block.
// Assumes: All pins are push-pull and change just after a rising pixel clock.
// Notes:   Clamp and coast pins follow levels that the bench commands.
`timescale 1ns/100ps
module video_src #(
    parameter int HS_PERIOD = 60,        // Pixel clocks per line.
    parameter int HS_WIDTH  = 4,         // Hsync active clocks.
    parameter int VS_LINES  = 8          // Lines per frame; vsync spans line 0.
) (
    input  wire logic i_clk,             // Pixel clock.
    input  wire logic i_rst,             // Asynchronous reset, active high.
    input  wire logic i_clamp_lvl,       // Level wanted on the clamp pin.
    input  wire logic i_coast_lvl,       // Level wanted on the coast pin.
    output logic      o_hsync,           // Hsync pin, active high.
    output logic      o_vsync,           // Vsync pin, active high.
    output logic      o_ext_clamp,       // External clamp pin.
    output logic      o_ext_coast        // External coast pin.
);
    int pix;
    int line;

    ////////////////////////////////////////////////////////////////////////////
    // Line and frame timing run on the pixel clock, so counts match the block.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pix         <= 0;
            line        <= 0;
            o_hsync     <= 1'b0;
            o_vsync     <= 1'b0;
            o_ext_clamp <= 1'b0;
            o_ext_coast <= 1'b0;
        end else begin
            if (pix == HS_PERIOD - 1) begin
                pix  <= 0;
                line <= (line == VS_LINES - 1) ? 0 : line + 1;
            end else begin
                pix <= pix + 1;
            end
            o_hsync     <= (pix < HS_WIDTH);
            o_vsync     <= (line == 0);
            o_ext_clamp <= i_clamp_lvl;
            o_ext_coast <= i_coast_lvl;
        end
    end
endmodule

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the clamp, coast and auto-offset block.
// Assumes: The slave may stretch any access; pin paths settle within 8 clocks.
// Notes:   Automatic polarity learning needs a level held for over 4095 clocks.
`timescale 1ns/100ps
module tb;
    import clamp_ctl_pkg::*;
    localparam int PER = 60;
    logic        i_clk, i_rst, rd, wr, hsync, vsync, ext_clamp, ext_coast;
    logic        clamp, coast, ofs_upd, waitreq, clamp_lvl, coast_lvl;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rq;
    logic [3:0]  ben;
    logic [2:0]  clamp_mid;
    int          num_errors = 0;
    int          cmp_count  = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Design, far-side model and clock.
    clamp_coast_ctl dut (.i_clk(i_clk), .i_rst(i_rst), .i_address(addr), .i_read(rd), .i_write(wr),
        .i_writedata(wdata), .i_byteenable(ben), .o_readdata(rdata), .o_waitrequest(waitreq),
        .i_hsync(hsync), .i_vsync(vsync), .i_ext_clamp(ext_clamp), .i_ext_coast(ext_coast),
        .o_clamp(clamp), .o_coast(coast), .o_clamp_mid(clamp_mid), .o_offset_update(ofs_upd));
    video_src #(.HS_PERIOD(PER)) src (.i_clk(i_clk), .i_rst(i_rst), .i_clamp_lvl(clamp_lvl),
        .i_coast_lvl(coast_lvl), .o_hsync(hsync), .o_vsync(vsync), .o_ext_clamp(ext_clamp),
        .o_ext_coast(ext_coast));
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks: verdict, compare, bus access and bounded waits.
    task final_report;
        $display("Counts: compares=%0d mismatches=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task hang;
        $display("Timeout at %0t", $time);
        num_errors++;
        final_report;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // The request holds until the edge where waitrequest is low; a slow slave just stretches it.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge i_clk);
        while (waitreq !== 1'b0 && n < 50) begin
            @(posedge i_clk);
            n++;
        end
        rq = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (n >= 50) hang();
    endtask
    task automatic drv(input logic coast_pin, input logic v);
        @(posedge i_clk);
        if (coast_pin) coast_lvl <= v;
        else clamp_lvl <= v;
        repeat (8) @(negedge i_clk);
    endtask
    task automatic wait_vs(input logic v);
        int n;
        n = 0;
        while (vsync !== v && n < 10 * PER) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 10 * PER) hang();
        repeat (8) @(negedge i_clk);
    endtask
    // Delay from the hsync pin fall to clamp rise, then the clamp width.
    task automatic meas(output int dly, output int wid);
        int n;
        n = 0;
        while (hsync !== 1'b1 && n < 2 * PER) begin
            @(negedge i_clk);
            n++;
        end
        while (hsync === 1'b1 && n < 3 * PER) begin
            @(negedge i_clk);
            n++;
        end
        dly = 0;
        while (clamp !== 1'b1 && dly < PER) begin
            @(negedge i_clk);
            dly++;
        end
        wid = 0;
        while (clamp === 1'b1 && wid < PER) begin
            @(negedge i_clk);
            wid++;
        end
        if (n >= 3 * PER || dly >= PER || wid >= PER) hang();
    endtask
    // The window starts mid-line so it holds exactly the given number of clamps and vsyncs.
    task automatic ao_count(input logic [7:0] cfg, input int lines, input int exp);
        int n;
        int k;
        bus(1'b1, ADDR_CLAMP_POL_AO, {24'h0, cfg});
        n = 0;
        while (clamp !== 1'b1 && n < 2 * PER) begin
            @(negedge i_clk);
            n++;
        end
        while (clamp === 1'b1 && n < 3 * PER) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 3 * PER) hang();
        k = 0;
        repeat (lines * PER) begin
            @(negedge i_clk);
            if (ofs_upd === 1'b1) k++;
        end
        check(k, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task t_regs;
        bus(1'b0, ADDR_COAST_CLAMP_CTRL, 32'h0);
        check(rq, 32'h20);
        bus(1'b0, ADDR_CLAMP_START, 32'h0);
        check(rq, 32'h08);
        bus(1'b0, ADDR_CLAMP_LENGTH, 32'h0);
        check(rq, 32'h20);
        bus(1'b0, ADDR_CLAMP_POL_AO, 32'h0);
        check(rq, 32'h5b);
        bus(1'b1, 8'h30, 32'hff);
        bus(1'b0, 8'h30, 32'h0);
        check(rq, 32'h0);
        $display("t_regs done");
    endtask
    task t_mid;
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, ADDR_COAST_CLAMP_CTRL, {28'h0, i[2:0], 1'b0});
            repeat (3) @(negedge i_clk);
            check(clamp_mid, i[2:0]);
        end
        $display("t_mid done");
    endtask
    task t_int_clamp;
        int d1, w1, d2, w2;
        bus(1'b1, ADDR_COAST_CLAMP_CTRL, 32'h0);
        bus(1'b1, ADDR_CLAMP_START, 32'h2);
        bus(1'b1, ADDR_CLAMP_LENGTH, 32'h3);
        meas(d1, w1);
        check(w1, 3);
        bus(1'b1, ADDR_CLAMP_START, 32'h9);
        bus(1'b1, ADDR_CLAMP_LENGTH, 32'h1);
        meas(d2, w2);
        check(d2 - d1, 7);
        check(w2, 1);
        bus(1'b0, ADDR_CLAMP_START, 32'h0);
        check(rq, 32'h09);
        $display("t_int_clamp done");
    endtask
    task t_ext_clamp;
        int k;
        bus(1'b1, ADDR_COAST_CLAMP_CTRL, 32'h10);
        bus(1'b1, ADDR_CLAMP_POL_AO, 32'hdb);
        drv(1'b0, 1'b0);
        k = 0;
        repeat (2 * PER) begin
            @(negedge i_clk);
            if (clamp === 1'b1) k++;
        end
        check(k, 0);
        drv(1'b0, 1'b1);
        check(clamp, 1'b1);
        bus(1'b1, ADDR_CLAMP_POL_AO, 32'h9b);
        drv(1'b0, 1'b1);
        check(clamp, 1'b0);
        drv(1'b0, 1'b0);
        check(clamp, 1'b1);
        // Automatic mode learns a long high level as idle, against the programmed bit.
        bus(1'b1, ADDR_CLAMP_POL_AO, 32'h5b);
        drv(1'b0, 1'b1);
        repeat (4200) @(negedge i_clk);
        check(clamp, 1'b0);
        drv(1'b0, 1'b0);
        check(clamp, 1'b1);
        $display("t_ext_clamp done");
    endtask
    task t_coast;
        bus(1'b1, ADDR_COAST_CLAMP_CTRL, 32'h0);
        wait_vs(1'b1);
        check(coast, 1'b1);
        wait_vs(1'b0);
        check(coast, 1'b0);
        bus(1'b1, ADDR_COAST_CLAMP_CTRL, 32'he0);
        drv(1'b1, 1'b0);
        wait_vs(1'b1);
        check(coast, 1'b0);
        drv(1'b1, 1'b1);
        check(coast, 1'b1);
        bus(1'b1, ADDR_COAST_CLAMP_CTRL, 32'hc0);
        drv(1'b1, 1'b1);
        check(coast, 1'b0);
        drv(1'b1, 1'b0);
        check(coast, 1'b1);
        // Automatic mode learns a long high level as idle, against the programmed bit.
        bus(1'b1, ADDR_COAST_CLAMP_CTRL, 32'ha0);
        drv(1'b1, 1'b1);
        repeat (4200) @(negedge i_clk);
        check(coast, 1'b0);
        drv(1'b1, 1'b0);
        check(coast, 1'b1);
        $display("t_coast done");
    endtask
    task t_ao;
        bus(1'b1, ADDR_COAST_CLAMP_CTRL, 32'h0);
        ao_count(8'h23, 8, 8);
        ao_count(8'h2b, 32, 2);
        ao_count(8'h33, 64, 1);
        ao_count(8'h3b, 32, 4);
        ao_count(8'h1b, 8, 0);
        $display("t_ao done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        i_rst     = 1'b1;
        rd        = 1'b0;
        wr        = 1'b0;
        addr      = 8'h00;
        wdata     = 32'h0;
        ben       = 4'h1;
        clamp_lvl = 1'b0;
        coast_lvl = 1'b0;
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs;
        t_mid;
        t_int_clamp;
        t_ext_clamp;
        t_coast;
        t_ao;
        final_report;
    end
endmodule
